// [sucp_port.sv]
// serial command port of the uart: frame shifter, config and data decode
//
// Functional notes
// - bits 15:14 select one of four operations
// - read config returns fields; write config zeros
// - config bit 7 selects infrared pulse timing
// - config bit 4 one means seven bits
// - write data bit 9 one drives handshake low
// - data ops return bit 9 one when cts low
// - reply bit 15 flags received data waiting
// - reply bit 14 flags transmit buffer empty
`timescale 1ns/100ps
`default_nettype none
`include "sucp_defs.svh"
module sucp_port (
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             nrst_in,
  // serial link pins
  input  wire logic             sclk_in,
  input  wire logic             n_cs_in,
  input  wire logic             mosi_in,
  output logic                  miso_out,
  output logic                  miso_oe_out,
  // handshake pins
  input  wire logic             n_cts_in,
  output logic                  n_rts_out,
  // uart engine side
  input  wire logic             rx_valid_in,
  input  wire logic [7:0]       rx_char_in,
  input  wire logic             rx_ninth_bit_in,
  input  wire logic             overrun_or_frame_error_in,
  input  wire logic             tx_empty_in,
  output logic                  rx_pop_out,
  output logic                  tx_push_out,
  output logic [7:0]            tx_char_out,
  output logic                  tx_ninth_bit_out,
  output logic                  tx_output_inhibit_out,
  output logic [13:0]           config_out,
  output logic                  infrared_timing_select_out,
  output logic                  seven_bit_select_out
);
  import sucp_pkg::*;

  // ----------------------------------------
  // pin synchronisation
  // ----------------------------------------
  logic [3:0] pins_s;
  logic       sclk_s, cs_act_s, mosi_s, cts_low_s;
  // chip select and cts are active low: inverted so reset value means idle
  sucp_sync #(.WIDTH(4)) u_sync (
    .clk_in     (ref_clk_in),
    .nrst_in    (nrst_in),
    .d_in       ({sclk_in, n_cs_in, mosi_in, n_cts_in}),
    .rst_val_in (`SUCP_SYNC_INV),
    .q_out      (pins_s)
  );
  assign sclk_s    = pins_s[3];
  assign cs_act_s  = pins_s[2];
  assign mosi_s    = pins_s[1];
  assign cts_low_s = pins_s[0];

  logic sclk_d_r, cs_d_r;
  logic sclk_rise, sclk_fall, frame_start, frame_end;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      cs_d_r   <= cs_act_s;
    end
  end
  assign sclk_rise   = sclk_s & ~sclk_d_r & cs_act_s;
  assign sclk_fall   = ~sclk_s & sclk_d_r & cs_act_s;
  assign frame_start = cs_act_s & ~cs_d_r;
  assign frame_end   = ~cs_act_s & cs_d_r;

  // ----------------------------------------
  // shift registers
  // ----------------------------------------
  sucp_word_t               rx_sh_r, tx_sh_r, reply;
  logic [`SUCP_CNT_W-1:0]   bit_cnt_r;
  logic [13:0]              cfg_r;
  logic                     shdn_r;
  logic                     hs_low_r;

  // opcode peeked while shifting decides reply body
  sucp_op_e peek_op;
  assign peek_op = sucp_op_e'({rx_sh_r[0], mosi_s});

  always_comb begin
    reply = '0;
    reply[`SUCP_BIT_RXAVAIL] = rx_valid_in;
    reply[`SUCP_BIT_TXEMPTY] = tx_empty_in;
  end

  // reply needs opcode, known only after two bits; body loads on bit-2 edge
  // one shift has already happened then, so the body sits one place higher
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_sh_r   <= '0;
      tx_sh_r   <= '0;
      bit_cnt_r <= '0;
    end else if (frame_start) begin
      tx_sh_r   <= reply;
      bit_cnt_r <= '0;
    end else if (sclk_rise) begin
      rx_sh_r <= {rx_sh_r[`SUCP_WORD_W-2:0], mosi_s};
      if (bit_cnt_r != `SUCP_WORD_BITS) begin
        bit_cnt_r <= bit_cnt_r + 1'b1;
      end
      if (bit_cnt_r == 5'h01) begin
        case (peek_op)
          // config fields on read, zeros on write
          SUCP_OP_RD_CFG: begin
            tx_sh_r <= {tx_sh_r[`SUCP_WORD_W-1],
                        cfg_r[13], shdn_r, cfg_r[11:0], 1'b0};
          end
          SUCP_OP_WR_CFG: begin
            tx_sh_r <= {tx_sh_r[`SUCP_WORD_W-1], 14'h0000, 1'b0};
          end
          default: begin
            // cts low reads back as one
            tx_sh_r <= {tx_sh_r[`SUCP_WORD_W-1], 3'h0,
                        overrun_or_frame_error_in, cts_low_s,
                        rx_ninth_bit_in, rx_char_in, 1'b0};
          end
        endcase
      end
    end else if (sclk_fall) begin
      tx_sh_r <= {tx_sh_r[`SUCP_WORD_W-2:0], 1'b0};
    end
  end

  // miso shows the msb of the reply shifter while selected
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      miso_out    <= 1'b0;
      miso_oe_out <= 1'b0;
    end else begin
      miso_out    <= tx_sh_r[`SUCP_WORD_W-1];
      miso_oe_out <= cs_act_s;
    end
  end

  // ----------------------------------------
  // command execution at frame close
  // ----------------------------------------
  logic     done;
  sucp_op_e cmd_op;
  // only a frame of at least 16 bits is acted on
  assign done   = frame_end && (bit_cnt_r == `SUCP_WORD_BITS);
  assign cmd_op = sucp_op_e'(rx_sh_r[`SUCP_OP_HI:`SUCP_OP_LO]);

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_r  <= `SUCP_CFG_RST;
      shdn_r <= 1'b0;
    end else if (done && cmd_op == SUCP_OP_WR_CFG) begin
      cfg_r  <= rx_sh_r[`SUCP_CFG_HI:0];
      shdn_r <= rx_sh_r[`SUCP_BIT_SHDN];
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hs_low_r              <= 1'b0;
      tx_push_out           <= 1'b0;
      rx_pop_out            <= 1'b0;
      tx_char_out           <= 8'h00;
      tx_ninth_bit_out      <= 1'b0;
      tx_output_inhibit_out <= 1'b0;
    end else begin
      tx_push_out <= done && cmd_op == SUCP_OP_WR_DATA;
      rx_pop_out  <= done && !cmd_op[1] && cmd_op == SUCP_OP_RD_DATA && rx_valid_in;
      if (done && cmd_op == SUCP_OP_WR_DATA) begin
        // bit 9 one pulls handshake output low
        hs_low_r              <= rx_sh_r[`SUCP_BIT_HSHAKE];
        tx_char_out           <= rx_sh_r[7:0];
        tx_ninth_bit_out      <= rx_sh_r[`SUCP_BIT_NINTH];
        tx_output_inhibit_out <= rx_sh_r[`SUCP_BIT_INHIBIT];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      n_rts_out                  <= 1'b1;
      config_out                 <= `SUCP_CFG_RST;
      infrared_timing_select_out <= 1'b0;
      seven_bit_select_out       <= 1'b0;
    end else begin
      n_rts_out                  <= ~hs_low_r;
      config_out                 <= cfg_r;
      infrared_timing_select_out <= cfg_r[`SUCP_BIT_IRDA];
      seven_bit_select_out       <= cfg_r[`SUCP_BIT_SEVEN];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_cfg_update: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (done && cmd_op == SUCP_OP_WR_CFG) |=> cfg_r == $past(rx_sh_r[13:0]))
    else $error("config not stored after write frame");
  a_short_ignored: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (frame_end && bit_cnt_r != `SUCP_WORD_BITS) |=> $stable(cfg_r) && !tx_push_out)
    else $error("short frame changed state");
  a_irda_follow: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    ##1 infrared_timing_select_out == $past(cfg_r[7]))
    else $error("infrared select does not follow config");
  a_seven_follow: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    ##1 seven_bit_select_out == $past(cfg_r[4]))
    else $error("length select does not follow config");
  a_rts_level: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (done && cmd_op == SUCP_OP_WR_DATA) |=> ##1 n_rts_out == !$past(rx_sh_r[9], 2))
    else $error("handshake output wrong level");
  a_wrcfg_zero: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (sclk_rise && bit_cnt_r == 5'h01 && peek_op == SUCP_OP_WR_CFG) |=> tx_sh_r[14:1] == 14'h0000)
    else $error("write config reply not zero");
  a_cts_reply: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (sclk_rise && bit_cnt_r == 5'h01 && !peek_op[0]) |=> tx_sh_r[10] == $past(cts_low_s))
    else $error("cts reply wrong");
  a_flags_load: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    frame_start |=> tx_sh_r[15] == $past(rx_valid_in) && tx_sh_r[14] == $past(tx_empty_in))
    else $error("status flags not loaded at frame start");
  c_wr_cfg: cover property (@(posedge ref_clk_in) done && cmd_op == SUCP_OP_WR_CFG);
  c_wr_data: cover property (@(posedge ref_clk_in) done && cmd_op == SUCP_OP_WR_DATA);
  c_rd_data: cover property (@(posedge ref_clk_in) rx_pop_out);
  c_short: cover property (@(posedge ref_clk_in) frame_end && bit_cnt_r != `SUCP_WORD_BITS);
endmodule
`default_nettype wire

// [sucp_defs.svh]
// constants for the serial command port of the uart
`ifndef SUCP_DEFS_SVH
`define SUCP_DEFS_SVH
`define SUCP_WORD_W        16
`define SUCP_OP_HI         15
`define SUCP_OP_LO         14
`define SUCP_CFG_HI        13
`define SUCP_CFG_W         14
`define SUCP_BIT_RXAVAIL   15
`define SUCP_BIT_TXEMPTY   14
`define SUCP_BIT_SHDN      12
`define SUCP_BIT_IRDA      7
`define SUCP_BIT_SEVEN     4
`define SUCP_BIT_INHIBIT   10
`define SUCP_BIT_HSHAKE    9
`define SUCP_BIT_NINTH     8
`define SUCP_BIT_ERR       10
`define SUCP_CFG_RST       14'h0000
`define SUCP_SYNC_INV      4'h5
`define SUCP_CNT_W         5
`define SUCP_WORD_BITS     5'h10
`endif

// [sucp_pkg.sv]
// types of the serial command port
package sucp_pkg;
  typedef enum logic [1:0] {
    SUCP_OP_RD_DATA = 2'h0,
    SUCP_OP_RD_CFG  = 2'h1,
    SUCP_OP_WR_DATA = 2'h2,
    SUCP_OP_WR_CFG  = 2'h3
  } sucp_op_e;
  typedef logic [15:0] sucp_word_t;
endpackage

// [sucp_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module sucp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic [WIDTH-1:0] d_in,
  input  wire logic [WIDTH-1:0] rst_val_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_r;
  initial begin
    if (WIDTH < 1) $error("sucp_sync: WIDTH must be positive");
  end
  // reset to zero; lines set in rst_val_in are inverted here so idle-high reads zero
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in ^ rst_val_in;
      q_out  <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [sucp_host_model.sv]
// host serial master model that drives frames into the command port
`timescale 1ns/100ps
`default_nettype none
module sucp_host_model (
  // clock
  input  wire logic clk_in,
  // serial link pins
  input  wire logic miso_in,
  output logic      sclk_out,
  output logic      n_cs_out,
  output logic      mosi_out
);
  initial begin
    sclk_out = 1'b0;
    n_cs_out = 1'b1;
    mosi_out = 1'b0;
  end
  // ----------------------------------------
  // one frame, mode 0, 16 ref cycles a half
  // ----------------------------------------
  // short frames stop early to test refusal
  task automatic frame(input logic [15:0] w, input int nbits, output logic [15:0] r);
    r = 16'h0000;
    @(posedge clk_in);
    n_cs_out <= 1'b0;
    mosi_out <= w[15];
    repeat (16) @(posedge clk_in);
    for (int i = 0; i < nbits; i++) begin
      sclk_out <= 1'b1;
      r = {r[14:0], miso_in};
      repeat (16) @(posedge clk_in);
      sclk_out <= 1'b0;
      if (i < 15) mosi_out <= w[14-i];
      repeat (16) @(posedge clk_in);
    end
    n_cs_out <= 1'b1;
    // released line must not keep the last bit
    mosi_out <= ~mosi_out;
    repeat (8) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// [spi_uart_command_port_tb_top.sv]
// self-checking bench for the serial command port
`timescale 1ns/100ps
`default_nettype none
module spi_uart_command_port_tb_top;
  import sucp_pkg::*;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       sclk, n_cs, mosi, miso, miso_oe, n_rts, rx_pop, tx_push;
  logic       n_cts = 1'b1;
  logic       rx_valid = 1'b0;
  logic [7:0] rx_char = 8'h00;
  logic       rx_ninth = 1'b0;
  logic       rx_err = 1'b0;
  logic       tx_empty = 1'b1;
  logic [7:0] tx_char;
  logic       tx_ninth, tx_inh, ir_sel, seven_sel;
  logic [13:0] cfg;
  sucp_word_t rep;
  int         n_errors = 0;
  int         comparisons = 0;
  int         n_push = 0;
  int         n_pop = 0;
  int         n_oe = 0;
  int         p, q;
  always #2.5 clk = ~clk;
  sucp_host_model host_u (.clk_in(clk), .miso_in(miso), .sclk_out(sclk), .n_cs_out(n_cs), .mosi_out(mosi));
  sucp_port dut_u (
    .ref_clk_in(clk), .nrst_in(nrst), .sclk_in(sclk), .n_cs_in(n_cs), .mosi_in(mosi),
    .miso_out(miso), .miso_oe_out(miso_oe), .n_cts_in(n_cts), .n_rts_out(n_rts),
    .rx_valid_in(rx_valid), .rx_char_in(rx_char), .rx_ninth_bit_in(rx_ninth),
    .overrun_or_frame_error_in(rx_err), .tx_empty_in(tx_empty), .rx_pop_out(rx_pop),
    .tx_push_out(tx_push), .tx_char_out(tx_char), .tx_ninth_bit_out(tx_ninth),
    .tx_output_inhibit_out(tx_inh), .config_out(cfg), .infrared_timing_select_out(ir_sel),
    .seven_bit_select_out(seven_sel));
  always @(posedge clk) begin
    if (tx_push === 1'b1) n_push <= n_push + 1;
    if (rx_pop === 1'b1) n_pop <= n_pop + 1;
    if (miso_oe === 1'b1) n_oe <= n_oe + 1;
  end
  // ----------------
  // shared tasks
  // ----------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic op(input sucp_op_e o, input logic [13:0] f);
    host_u.frame({o, f}, 16, rep);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_config();
    p = n_oe;
    op(SUCP_OP_WR_CFG, 14'h2A95);
    chk(rep, 16'h4000, "wr cfg reply");
    chk(16'(n_oe - p), 16'h0210, "oe frame length");
    chk({2'h0, cfg}, 16'h2A95, "cfg stored");
    chk({14'h0, ir_sel, seven_sel}, 16'h0003, "ir seven set");
    op(SUCP_OP_RD_CFG, 14'h0001);
    chk(rep, 16'h6A95, "rd cfg reply");
    op(SUCP_OP_WR_CFG, 14'h156A);
    chk({14'h0, ir_sel, seven_sel}, 16'h0000, "ir seven clear");
    $display("test config done");
  endtask
  task automatic t_data();
    @(posedge clk);
    n_cts <= 1'b0;
    rx_valid <= 1'b1;
    rx_char <= 8'hC3;
    rx_ninth <= 1'b1;
    rx_err <= 1'b1;
    tx_empty <= 1'b0;
    p = n_push;
    q = n_pop;
    op(SUCP_OP_WR_DATA, 14'h07A5);
    chk(rep, 16'h87C3, "wr data reply");
    chk(16'(n_push - p), 16'h0001, "one push");
    chk({5'h0, tx_inh, ~n_rts, tx_ninth, tx_char}, 16'h07A5, "tx fields");
    chk({15'h0, n_rts}, 16'h0000, "rts low");
    n_cts <= 1'b1;
    rx_err <= 1'b0;
    op(SUCP_OP_WR_DATA, 14'h0000);
    chk(rep, 16'h81C3, "cts high reply");
    chk({15'h0, n_rts}, 16'h0001, "rts high");
    chk(16'(n_pop - q), 16'h0000, "no pop on write");
    $display("test data done");
  endtask
  task automatic t_read();
    tx_empty <= 1'b1;
    q = n_pop;
    op(SUCP_OP_RD_DATA, 14'h0000);
    chk(rep, 16'hC1C3, "rd data reply");
    chk(16'(n_pop - q), 16'h0001, "one pop");
    rx_valid <= 1'b0;
    op(SUCP_OP_RD_DATA, 14'h0000);
    chk({14'h0, rep[15:14]}, 16'h0001, "rx empty flag");
    chk(16'(n_pop - q), 16'h0001, "no pop when empty");
    $display("test read done");
  endtask
  task automatic t_short();
    p = n_push;
    host_u.frame({SUCP_OP_WR_CFG, 14'h3FFF}, 15, rep);
    chk({2'h0, cfg}, 16'h156A, "short cfg kept");
    host_u.frame({SUCP_OP_WR_DATA, 14'h00FF}, 15, rep);
    chk(16'(n_push - p), 16'h0000, "short no push");
    $display("test short done");
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    $display("CHECK FAILED at %0t: run limit", $time);
    results();
  end
  initial begin
    repeat (12) @(posedge clk);
    chk({13'h0, n_rts, miso_oe, 1'b0}, 16'h0004, "reset pins");
    chk({2'h0, cfg}, 16'h0000, "reset cfg");
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_config();
    t_data();
    t_read();
    t_short();
    results();
  end
endmodule
`default_nettype wire
